// *** rtl/sbi_defines.svh ***
// constants of the system bus board interface and its far end
`ifndef SBI_DEFINES_SVH
`define SBI_DEFINES_SVH

// ----------------------------------------------------------------
// backplane layout
// ----------------------------------------------------------------
`define SBI_TOP_BIT     19
`define SBI_IRQ_CLR_PORT 16'h7fb3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SBI_CLK_MHZ     100
`define SBI_TMO_US      20
`define SBI_TMO_CYC     (`SBI_TMO_US * `SBI_CLK_MHZ)
`define SBI_TMR_W       12
`define SBI_TMR_ZERO    12'h000
`define SBI_TMR_ONE     12'h001
`define SBI_TMO_LAST    12'(`SBI_TMO_CYC - 1)

// ----------------------------------------------------------------
// far end wishbone registers
// ----------------------------------------------------------------
`define SBI_WB_CTRL     8'h00
`define SBI_WB_ADDR     8'h04
`define SBI_WB_WDATA    8'h08
`define SBI_WB_RDATA    8'h0c
`define SBI_WB_IODATA   8'h10
`define SBI_WB_IOLAST   8'h14
`define SBI_WB_IOCFG    8'h18
`define SBI_CTRL_GO     0
`define SBI_CTRL_WR     1
`define SBI_CTRL_WORD   2
`define SBI_STAT_BUSY   0
`define SBI_STAT_DONE   1
`define SBI_IOCFG_ACK   0

`endif

// *** rtl/sbi_pkg.sv ***
// types shared by both ends of the system bus interface
`default_nettype none
package sbi_pkg;

  // ----------------------------------------------------------------
  // state enums
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SS_IDLE, SS_MEM, SS_ACK} sbi_slv_e;
  typedef enum logic [3:0] {MS_IDLE, MS_ARB, MS_CMD, MS_END, MS_R0,
                            MS_R1, MS_R2, MS_R3, MS_R4} sbi_mst_e;
  typedef enum logic [1:0] {FM_IDLE, FM_WAIT, FM_CMD, FM_REL} sbi_fm_e;
  typedef enum logic [0:0] {FI_IDLE, FI_ACK} sbi_fi_e;

  // ----------------------------------------------------------------
  // board end state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        mr1, mr2, mw1, mw2, bu1, bu2, xk1, xk2;
    sbi_slv_e    sst;
    logic        s_req, s_wr, s_xack, s_dat_oe;
    logic [19:0] s_adr;
    logic [15:0] s_wdat, s_rdat;
    logic [1:0]  s_lanes;
    sbi_mst_e    mst;
    logic        as_q, ds_q, ds_low;
    logic        io_req, breq, busy, owned, cmd_rd, cmd_wr;
    logic        adr_oe, dat_oe, m_wr, m_bhen_n, ready, irq;
    logic [15:0] m_adr, m_wdat, cpu_rdat;
    logic [11:0] tmr;
  } sbi_dev_s;

  // ----------------------------------------------------------------
  // far end state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        bu1, bu2, xk1, xk2, rd1, rd2, wr1, wr2, bq1, bq2;
    logic        ack;
    logic [31:0] rdat;
    sbi_fm_e     fst;
    logic [19:0] m_adr;
    logic [15:0] m_wdat, m_rdat, io_data, io_ladr, io_ldat;
    logic        m_wr, m_word, done, busy, cmd_rd, cmd_wr, dat_oe;
    sbi_fi_e     ist;
    logic        ack_en, xack, io_oe;
  } sbi_far_s;

  // byte lanes: word when byte-high enable active, else by address bit 0
  function automatic logic [1:0] sbi_lanes(input logic a0,
                                           input logic bhen_n);
    sbi_lanes = !bhen_n ? 2'h3 : (a0 ? 2'h2 : 2'h1);
  endfunction

endpackage
`default_nettype wire

// *** rtl/sbi_if.sv ***
// backplane between the board interface and the far masters and slaves
`timescale 1ns/10ps
`default_nettype none
interface sbi_if;
  // ----------------------------------------------------------------
  // memory cycle lines, driven by the far master
  // ----------------------------------------------------------------
  logic [19:0] mem_adr;
  logic        mem_bhen_n;
  logic        mrdc_n;
  logic        mwtc_n;
  // ----------------------------------------------------------------
  // i/o cycle lines, driven by the board
  // ----------------------------------------------------------------
  logic [15:0] io_adr;
  logic        io_bhen_n;
  logic        iord_n;
  logic        iowr_n;
  logic        breq_n;
  // ----------------------------------------------------------------
  // shared data and open-drain lines
  // ----------------------------------------------------------------
  logic [15:0] dev_dat;
  logic        dev_dat_oe;
  logic [15:0] far_dat;
  logic        far_dat_oe;
  logic [15:0] dat;
  logic        dev_xack_oe;
  logic        far_xack_oe;
  logic        xack_n;
  logic        dev_busy_oe;
  logic        far_busy_oe;
  logic        busy_n;

  assign dat    = dev_dat_oe ? dev_dat : (far_dat_oe ? far_dat : 16'h0000);
  assign xack_n = !(dev_xack_oe || far_xack_oe);
  assign busy_n = !(dev_busy_oe || far_busy_oe);

  modport dev (input mem_adr, mem_bhen_n, mrdc_n, mwtc_n, dat, xack_n,
               busy_n, output io_adr, io_bhen_n, iord_n, iowr_n, breq_n,
               dev_dat, dev_dat_oe, dev_xack_oe, dev_busy_oe);
  modport far (output mem_adr, mem_bhen_n, mrdc_n, mwtc_n, far_dat,
               far_dat_oe, far_xack_oe, far_busy_oe, input io_adr,
               io_bhen_n, iord_n, iowr_n, breq_n, dat, xack_n, busy_n);
endinterface
`default_nettype wire

// *** rtl/sbi_board_end.sv ***
// processor board end: memory slave and i/o master on the backplane
`timescale 1ns/10ps
`default_nettype none
`include "sbi_defines.svh"

// Function
// - master reaches 64K sixteen-bit i/o ports
// - slave answers upper half of memory only
// - byte and word transfers both directions
// - request needs top address and command
// - slave request asks local arbiter for bus
// - read data latched at memory cycle end
// - local memory freed once data latched
// - acknowledge requester after local access
// - requester withdraws command, ending cycle
// - i/o access starts at strobe rising edge
// - bus request comes through a flip-flop
// - backplane resolves ownership by slot priority
// - start when busy high, else wait
// - pull busy low while owning bus
// - owning bus: indicate, buffers, address; timer from access start
// - acknowledge releases processor wait line
// - 20 us without acknowledge: interrupt, release
// - timeout interrupt cleared by port write
// - data strobe end releases lines in order
module sbi_board_end (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  sbi_if.dev               bp,
  output logic             o_slave_local_bus_request,
  input  wire logic        i_slave_local_bus_grant_n,
  input  wire logic        i_memory_cycle_done_n,
  input  wire logic [15:0] i_mem_rdata,
  output logic [19:0]      o_mem_addr,
  output logic [15:0]      o_mem_wdata,
  output logic [1:0]       o_mem_lanes,
  output logic             o_mem_write,
  input  wire logic        i_cpu_address_strobe_n,
  input  wire logic        i_cpu_data_strobe_n,
  input  wire logic        i_cpu_std_io,
  input  wire logic        i_cpu_write,
  input  wire logic        i_cpu_word,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [15:0] i_cpu_wdata,
  output logic             o_master_io_request,
  output logic             o_bus_owned_indication,
  output logic             o_cpu_wait_n,
  output logic [15:0]      o_cpu_rdata,
  output logic             o_bus_timeout_irq
);
  import sbi_pkg::*;

  sbi_dev_s r;
  sbi_dev_s next_r;
  logic     as_rise;
  logic     irq_clr;
  logic     tmo;

  always_comb begin
    next_r  = r;
    as_rise = 1'b0;
    irq_clr = 1'b0;
    tmo     = 1'b0;
    // ----------------------------------------------------------------
    // backplane synchronisers, held active high
    // ----------------------------------------------------------------
    next_r.mr1 = !bp.mrdc_n;
    next_r.mr2 = r.mr1;
    next_r.mw1 = !bp.mwtc_n;
    next_r.mw2 = r.mw1;
    next_r.bu1 = !bp.busy_n;
    next_r.bu2 = r.bu1;
    next_r.xk1 = !bp.xack_n;
    next_r.xk2 = r.xk1;

    // ----------------------------------------------------------------
    // memory slave
    // ----------------------------------------------------------------
    unique case (r.sst)
      SS_IDLE: begin
        // address and data are stable once the command is seen
        if ((r.mr2 || r.mw2) && bp.mem_adr[`SBI_TOP_BIT]) begin
          next_r.s_req   = 1'b1;
          next_r.s_adr   = bp.mem_adr;
          next_r.s_wdat  = bp.dat;
          next_r.s_wr    = r.mw2;
          next_r.s_lanes = sbi_lanes(bp.mem_adr[0], bp.mem_bhen_n);
          next_r.sst     = SS_MEM;
        end
      end
      SS_MEM: begin
        if (!i_slave_local_bus_grant_n && !i_memory_cycle_done_n) begin
          next_r.s_rdat   = i_mem_rdata;
          next_r.s_req    = 1'b0;
          next_r.s_xack   = 1'b1;
          next_r.s_dat_oe = !r.s_wr;
          next_r.sst      = SS_ACK;
        end
      end
      SS_ACK: begin
        if (!r.mr2 && !r.mw2) begin
          next_r.s_xack   = 1'b0;
          next_r.s_dat_oe = 1'b0;
          next_r.sst      = SS_IDLE;
        end
      end
      default: next_r.sst = SS_IDLE;
    endcase

    // ----------------------------------------------------------------
    // i/o master
    // ----------------------------------------------------------------
    next_r.as_q = !i_cpu_address_strobe_n;
    next_r.ds_q = !i_cpu_data_strobe_n;
    as_rise     = r.as_q && i_cpu_address_strobe_n;

    // timer runs from the start of the access until answered
    if (r.io_req && !r.ready) begin
      next_r.tmr = r.tmr + `SBI_TMR_ONE;
      if (r.tmr == `SBI_TMO_LAST) begin
        tmo          = 1'b1;
        next_r.ready = 1'b1;
        next_r.mst   = MS_END;
      end
    end

    unique case (r.mst)
      MS_IDLE: begin
        if (as_rise && i_cpu_std_io) begin
          if (i_cpu_write && i_cpu_addr == `SBI_IRQ_CLR_PORT) begin
            irq_clr = 1'b1;
          end else begin
            next_r.io_req   = 1'b1;
            next_r.tmr      = `SBI_TMR_ZERO;
            next_r.m_adr    = i_cpu_addr;
            next_r.m_wdat   = i_cpu_wdata;
            next_r.m_wr     = i_cpu_write;
            next_r.m_bhen_n = !i_cpu_word;
            next_r.ready    = 1'b0;
            next_r.ds_low   = 1'b0;
            next_r.mst      = MS_ARB;
          end
        end
      end
      MS_ARB: begin
        next_r.breq = r.io_req;
        // the slot priority chain itself lives on the backplane
        if (r.breq && !r.bu2 && !tmo) begin
          next_r.busy   = 1'b1;
          next_r.owned  = 1'b1;
          next_r.adr_oe = 1'b1;
          next_r.dat_oe = r.m_wr;
          next_r.mst    = MS_CMD;
        end
      end
      MS_CMD: begin
        next_r.cmd_rd = !r.m_wr;
        next_r.cmd_wr = r.m_wr;
        if (r.xk2 && (r.cmd_rd || r.cmd_wr) && !tmo) begin
          next_r.ready    = 1'b1;
          next_r.cpu_rdat = bp.dat;
          next_r.mst      = MS_END;
        end
      end
      MS_END: begin
        if (r.ds_q) begin
          next_r.ds_low = 1'b1;
        end
        if (r.ds_low && !r.ds_q) begin
          next_r.io_req = 1'b0;
          next_r.mst    = MS_R0;
        end
      end
      MS_R0: begin
        next_r.breq = 1'b0;
        next_r.mst  = MS_R1;
      end
      MS_R1: begin
        next_r.owned = 1'b0;
        next_r.mst   = MS_R2;
      end
      MS_R2: begin
        next_r.cmd_rd = 1'b0;
        next_r.cmd_wr = 1'b0;
        next_r.mst    = MS_R3;
      end
      MS_R3: begin
        next_r.adr_oe = 1'b0;
        next_r.dat_oe = 1'b0;
        next_r.mst    = MS_R4;
      end
      MS_R4: begin
        next_r.busy = 1'b0;
        next_r.mst  = MS_IDLE;
      end
      default: next_r.mst = MS_IDLE;
    endcase

    // a timeout in the clearing cycle still leaves the flag set
    next_r.irq = tmo || (r.irq && !irq_clr);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_slave_local_bus_request = r.s_req;
  assign o_mem_addr                = r.s_adr;
  assign o_mem_wdata               = r.s_wdat;
  assign o_mem_lanes               = r.s_lanes;
  assign o_mem_write               = r.s_wr;
  assign o_master_io_request       = r.io_req;
  assign o_bus_owned_indication    = r.owned;
  assign o_cpu_wait_n              = !(r.io_req && !r.ready);
  assign o_cpu_rdata               = r.cpu_rdat;
  assign o_bus_timeout_irq         = r.irq;

  assign bp.io_adr      = r.adr_oe ? r.m_adr : 16'h0000;
  assign bp.io_bhen_n   = r.adr_oe ? r.m_bhen_n : 1'b1;
  assign bp.iord_n      = !r.cmd_rd;
  assign bp.iowr_n      = !r.cmd_wr;
  assign bp.breq_n      = !r.breq;
  assign bp.dev_dat     = r.dat_oe ? r.m_wdat : r.s_rdat;
  assign bp.dev_dat_oe  = r.dat_oe || r.s_dat_oe;
  assign bp.dev_xack_oe = r.s_xack;
  assign bp.dev_busy_oe = r.busy;
endmodule // sbi_board_end
`default_nettype wire

// *** rtl/sbi_far_end.sv ***
// far end: memory master and i/o slave, ordered over wishbone
`timescale 1ns/10ps
`default_nettype none
`include "sbi_defines.svh"

module sbi_far_end (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  sbi_if.far               bp,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack
);
  import sbi_pkg::*;

  sbi_far_s    r;
  sbi_far_s    next_r;
  logic        wr_en;
  logic        done_clr;
  logic        done_set;
  logic [31:0] wv;
  logic [1:0]  ln;

  always_comb begin
    next_r   = r;
    done_clr = 1'b0;
    done_set = 1'b0;
    ln       = sbi_lanes(bp.io_adr[0], bp.io_bhen_n);
    wv       = {i_wb_sel[3] ? i_wb_dat[31:24] : 8'h00,
                i_wb_sel[2] ? i_wb_dat[23:16] : 8'h00,
                i_wb_sel[1] ? i_wb_dat[15:8]  : 8'h00,
                i_wb_sel[0] ? i_wb_dat[7:0]   : 8'h00};
    wr_en    = i_wb_cyc && i_wb_stb && i_wb_we && !r.ack;
    // ----------------------------------------------------------------
    // synchronisers, held active high
    // ----------------------------------------------------------------
    next_r.bu1 = !bp.busy_n;
    next_r.bu2 = r.bu1;
    next_r.xk1 = !bp.xack_n;
    next_r.xk2 = r.xk1;
    next_r.rd1 = !bp.iord_n;
    next_r.rd2 = r.rd1;
    next_r.wr1 = !bp.iowr_n;
    next_r.wr2 = r.wr1;
    next_r.bq1 = !bp.breq_n;
    next_r.bq2 = r.bq1;

    // ----------------------------------------------------------------
    // wishbone slave, answer one cycle after the request
    // ----------------------------------------------------------------
    next_r.ack = i_wb_cyc && i_wb_stb && !r.ack;
    unique case (i_wb_adr)
      `SBI_WB_CTRL:   next_r.rdat = {30'h0, r.done, r.fst != FM_IDLE};
      `SBI_WB_ADDR:   next_r.rdat = {12'h000, r.m_adr};
      `SBI_WB_WDATA:  next_r.rdat = {16'h0000, r.m_wdat};
      `SBI_WB_RDATA:  next_r.rdat = {16'h0000, r.m_rdat};
      `SBI_WB_IODATA: next_r.rdat = {16'h0000, r.io_data};
      `SBI_WB_IOLAST: next_r.rdat = {r.io_ladr, r.io_ldat};
      `SBI_WB_IOCFG:  next_r.rdat = {31'h0, r.ack_en};
      default:        next_r.rdat = 32'h0000_0000;
    endcase
    if (wr_en) begin
      unique case (i_wb_adr)
        `SBI_WB_CTRL: begin
          next_r.m_wr   = wv[`SBI_CTRL_WR];
          next_r.m_word = wv[`SBI_CTRL_WORD];
          if (wv[`SBI_CTRL_GO] && r.fst == FM_IDLE) begin
            done_clr   = 1'b1;
            next_r.fst = FM_WAIT;
          end
        end
        `SBI_WB_ADDR:   next_r.m_adr   = wv[19:0];
        `SBI_WB_WDATA:  next_r.m_wdat  = wv[15:0];
        `SBI_WB_IODATA: next_r.io_data = wv[15:0];
        `SBI_WB_IOCFG:  next_r.ack_en  = wv[`SBI_IOCFG_ACK];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // memory master; defers to a board that asks for the bus
    // ----------------------------------------------------------------
    unique case (r.fst)
      FM_IDLE: ;
      FM_WAIT: begin
        if (!r.bu2 && !r.bq2) begin
          next_r.busy   = 1'b1;
          next_r.dat_oe = r.m_wr;
          next_r.fst    = FM_CMD;
        end
      end
      FM_CMD: begin
        next_r.cmd_rd = !r.m_wr;
        next_r.cmd_wr = r.m_wr;
        if (r.xk2 && (r.cmd_rd || r.cmd_wr)) begin
          next_r.m_rdat = bp.dat;
          next_r.cmd_rd = 1'b0;
          next_r.cmd_wr = 1'b0;
          next_r.fst    = FM_REL;
        end
      end
      FM_REL: begin
        if (!r.xk2) begin
          next_r.busy   = 1'b0;
          next_r.dat_oe = 1'b0;
          done_set      = 1'b1;
          next_r.fst    = FM_IDLE;
        end
      end
    endcase
    next_r.done = done_set || (r.done && !done_clr);

    // ----------------------------------------------------------------
    // i/o slave; no acknowledge when disabled, to provoke a timeout
    // ----------------------------------------------------------------
    unique case (r.ist)
      FI_IDLE: begin
        if (r.rd2 || r.wr2) begin
          if (r.wr2) begin
            next_r.io_ladr = bp.io_adr;
            next_r.io_ldat = {ln[1] ? bp.dat[15:8] : 8'h00,
                              ln[0] ? bp.dat[7:0]  : 8'h00};
          end
          next_r.xack  = r.ack_en;
          next_r.io_oe = r.rd2;
          next_r.ist   = FI_ACK;
        end
      end
      FI_ACK: begin
        if (!r.rd2 && !r.wr2) begin
          next_r.xack  = 1'b0;
          next_r.io_oe = 1'b0;
          next_r.ist   = FI_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_wb_dat       = r.rdat;
  assign o_wb_ack       = r.ack;
  assign bp.mem_adr     = r.m_adr;
  assign bp.mem_bhen_n  = !r.m_word;
  assign bp.mrdc_n      = !r.cmd_rd;
  assign bp.mwtc_n      = !r.cmd_wr;
  assign bp.far_dat     = r.dat_oe ? r.m_wdat : r.io_data;
  assign bp.far_dat_oe  = r.dat_oe || r.io_oe;
  assign bp.far_xack_oe = r.xack;
  assign bp.far_busy_oe = r.busy;
endmodule // sbi_far_end
`default_nettype wire

// *** dv/sbi_chk_asserts.sv ***
// backplane assertions between the board end and the far end
`timescale 1ns/10ps
`default_nettype none
module sbi_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [19:0] mem_adr,
  input wire logic        mrdc_n,
  input wire logic        mwtc_n,
  input wire logic        iord_n,
  input wire logic        iowr_n,
  input wire logic        breq_n,
  input wire logic        dev_dat_oe,
  input wire logic        dev_xack_oe,
  input wire logic        dev_busy_oe,
  input wire logic        far_busy_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_xack_upper: assert property (
    $rose(dev_xack_oe) |-> mem_adr[19])
    else $error("xack for lower half");
  a_xack_cmd: assert property (
    $rose(dev_xack_oe) |-> !($past(mrdc_n) && $past(mwtc_n)))
    else $error("xack without command");
  a_rd_data: assert property (
    $rose(dev_xack_oe) && !mrdc_n |-> dev_dat_oe)
    else $error("read xack without data");
  a_xack_drop: assert property (
    (mrdc_n && mwtc_n) [*4] |-> !dev_xack_oe)
    else $error("xack held after command gone");
  a_busy_breq: assert property (
    $rose(dev_busy_oe) |-> !$past(breq_n) && !$past(far_busy_oe))
    else $error("busy taken out of turn");
  a_cmd_owner: assert property (
    !(iord_n && iowr_n) |-> dev_busy_oe)
    else $error("command without busy");
  a_cmd_late: assert property (
    $fell(iord_n) || $fell(iowr_n) |-> $past(dev_busy_oe))
    else $error("command before ownership");
  a_rel_order: assert property (
    $fell(dev_busy_oe) |-> breq_n && $past(iord_n) && $past(iowr_n))
    else $error("busy released out of order");
  c_slv_rd: cover property ($rose(dev_xack_oe) && !mrdc_n);
  c_slv_wr: cover property ($rose(dev_xack_oe) && !mwtc_n);
  c_io_end: cover property ($fell(dev_busy_oe));
endmodule // sbi_chk
`default_nettype wire

// *** dv/system_bus_master_slave_interface_bench.sv ***
// self-checking bench joining the board end and the far end
`timescale 1ns/10ps
`default_nettype none
`include "sbi_defines.svh"
module system_bus_master_slave_interface_bench;
  logic        clk = 0, rst_n = 0, gnt_n = 1, done_n = 1;
  logic        as_n = 1, ds_n = 1, cwr = 0, cword = 0, stdio = 1;
  logic [15:0] rdv = 0, caddr = 0, cwdat = 0, crd, mwd;
  logic        sreq, mwr, ioreq, owned, wait_n, irq, wack;
  logic [19:0] madr;
  logic [1:0]  mln, own;
  logic        cyc = 0, stb = 0, we = 0;
  logic [7:0]  wadr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, wrd, r;
  int          n_fail = 0, num_checks = 0, n;

  sbi_if bp ();
  sbi_board_end i_sbi_board_end (.i_clk(clk), .i_rst_n(rst_n), .bp(bp.dev),
    .o_slave_local_bus_request(sreq), .i_slave_local_bus_grant_n(gnt_n),
    .i_memory_cycle_done_n(done_n), .i_mem_rdata(rdv), .o_mem_addr(madr),
    .o_mem_wdata(mwd), .o_mem_lanes(mln), .o_mem_write(mwr),
    .i_cpu_address_strobe_n(as_n), .i_cpu_data_strobe_n(ds_n),
    .i_cpu_std_io(stdio), .i_cpu_write(cwr), .i_cpu_word(cword),
    .i_cpu_addr(caddr), .i_cpu_wdata(cwdat), .o_master_io_request(ioreq),
    .o_bus_owned_indication(owned), .o_cpu_wait_n(wait_n),
    .o_cpu_rdata(crd), .o_bus_timeout_irq(irq));
  sbi_far_end i_sbi_far_end (.i_clk(clk), .i_rst_n(rst_n), .bp(bp.far),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(wadr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wrd), .o_wb_ack(wack));
  sbi_chk i_sbi_chk (.i_clk(clk), .i_rst_n(rst_n), .mem_adr(bp.mem_adr),
    .mrdc_n(bp.mrdc_n), .mwtc_n(bp.mwtc_n), .iord_n(bp.iord_n),
    .iowr_n(bp.iowr_n), .breq_n(bp.breq_n), .dev_dat_oe(bp.dev_dat_oe),
    .dev_xack_oe(bp.dev_xack_oe), .dev_busy_oe(bp.dev_busy_oe),
    .far_busy_oe(bp.far_busy_oe));

  always #5 clk = ~clk;
  // local arbiter and memory: grant and finish every slave request
  always @(posedge clk) begin
    gnt_n  <= !sreq;
    done_n <= !sreq;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task hang;
    n_fail++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 0, 1);
    give_verdict;
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int k;
    cyc <= 1; stb <= 1; we <= w; wadr <= a; wdat <= d; sel <= 4'hf;
    k = 0;
    do begin @(posedge clk); k++; end while (wack !== 1'b1 && k < 50);
    if (k >= 50) hang;
    q = wrd;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  task far_go(input logic w, wd, input logic [19:0] a, input logic [15:0] d);
    wb(1, `SBI_WB_ADDR, {12'h000, a}, r);
    wb(1, `SBI_WB_WDATA, {16'h0000, d}, r);
    wb(1, `SBI_WB_CTRL, {29'h0, wd, w, 1'b1}, r);
  endtask
  task far_wait;
    for (n = 0; n < 60; n++) begin
      wb(0, `SBI_WB_CTRL, 0, r);
      if (r[1]) return;
    end
    hang;
  endtask
  task wait_req;
    n = 0;
    while (sreq !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    if (n >= 50) hang;
  endtask
  task cpu_io(input logic w, wd, input logic [15:0] a, d);
    cwr <= w; cword <= wd; caddr <= a; cwdat <= d; as_n <= 0;
    @(posedge clk) as_n <= 1;
    tick(3);
    n = 2;
    while (wait_n !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
    if (n >= 3000) hang;
    own = {ioreq, owned};
    @(posedge clk) ds_n <= 0;
    @(posedge clk) ds_n <= 1;
    tick(8);
  endtask

  task slv_wr(input logic [19:0] a, input logic wd, input logic [15:0] d,
              input logic [1:0] ln);
    far_go(1, wd, a, d);
    wait_req;
    chk({madr, mwd, mln, mwr}, {a, d, ln, 1'b1});
    far_wait;
  endtask
  task t_slave;
    slv_wr(20'h80000, 1, 16'ha55a, 2'h3);
    slv_wr(20'hfff01, 0, 16'h00c3, 2'h2);
    slv_wr(20'h80002, 0, 16'h003c, 2'h1);
    rdv <= 16'hbeef;
    far_go(0, 1, 20'hc1234, 0);
    wait_req;
    chk({madr, mwr}, {20'hc1234, 1'b0});
    tick(2);
    // local request gone while the backplane read is still acknowledged
    chk({sreq, bp.dev_xack_oe, bp.mrdc_n}, 3'h2);
    far_wait;
    wb(0, `SBI_WB_RDATA, 0, r);
    chk(r[15:0], 16'hbeef);
    $display("slave test done");
  endtask
  task t_io;
    wb(1, `SBI_WB_IOCFG, 1, r);
    wb(1, `SBI_WB_IODATA, 32'h5a3c, r);
    cpu_io(0, 1, 16'h1234, 0);
    chk({own, crd}, {2'h3, 16'h5a3c});
    chk({ioreq, owned, wait_n, bp.dev_busy_oe, bp.breq_n}, 5'h05);
    cpu_io(1, 1, 16'hfffe, 16'hc0de);
    wb(0, `SBI_WB_IOLAST, 0, r);
    chk(r, 32'hfffec0de);
    cpu_io(1, 0, 16'h0011, 16'h1234);
    wb(0, `SBI_WB_IOLAST, 0, r);
    chk(r, 32'h00111200);
    $display("io test done");
  endtask
  task t_tmo;
    wb(1, `SBI_WB_IOCFG, 0, r);
    repeat (2) begin
      cpu_io(0, 1, 16'h0100, 0);
      chk(n > `SBI_TMO_CYC - 3 && n < `SBI_TMO_CYC + 4, 1);
      chk(irq, 1);
    end
    cpu_io(1, 0, `SBI_IRQ_CLR_PORT, 0);
    chk(irq, 0);
    // an access that is not standard i/o must not reach the backplane
    stdio <= 0;
    cpu_io(0, 1, 16'h0300, 0);
    chk({own, irq}, 3'h0);
    stdio <= 1;
    $display("timeout test done");
  endtask
  task t_lower;
    far_go(1, 1, 20'h7ffff, 16'h1111);
    n = 0;
    repeat (40) begin @(posedge clk); if (sreq !== 1'b0) n++; end
    chk(n, 0);
    cpu_io(0, 1, 16'h0200, 0);
    chk({own, irq}, 3'h5);
    $display("lower half test done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    tick(3);
    t_slave;
    t_io;
    t_tmo;
    t_lower;
    give_verdict;
  end
endmodule // system_bus_master_slave_interface_bench
`default_nettype wire
